/* include/srs_cfg.svh */
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SRS_CLK_NS 10
`define SRS_MS_NS 1000000
`define SRS_TIMEOUT_MS 17'd90000
`define SRS_LONG_MS 17'd8000
`define SRS_QUAL_MS 17'd1000
`define SRS_CHG_MS 17'd2000
`define SRS_SS_MS 17'd20
`define SRS_BLINK_MS 17'd250
`define SRS_RAND_SPAN 16'd2001
// ---------------------------------------------------------------
// efficiency table
// ---------------------------------------------------------------
`define SRS_EFF_PTS 19
`define SRS_EFF_RST 10'd960
`define SRS_EFF_SCALE 32'd1000
`define SRS_LOAD_MIN 32'd10
`define SRS_LOAD_STEP 32'd5
`define SRS_PCT 32'd100
// ---------------------------------------------------------------
// external link message kinds
// ---------------------------------------------------------------
`define SRS_MSG_REPORT 2'h1
`define SRS_MSG_FW 2'h2
`endif

/* include/srs_pkg.sv */
package srs_pkg;
  typedef struct packed {
    logic boost;
    logic main;
    logic aux;
    logic charger;
    logic stepUp;
    logic relay;
  } srs_enables_t;
  typedef struct packed {
    logic isSlot1;
    logic slot1Present;
    logic slot1InTest;
    logic peerAlive;
    logic syncIn;
  } srs_shelf_t;
  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_RAMP = 8'h02,
    ST_RUN = 8'h04,
    ST_TEST = 8'h08,
    ST_BACKUP = 8'h10,
    ST_QUAL = 8'h20,
    ST_DELAY = 8'h40,
    ST_WAIT = 8'h80
  } srs_state_t;
endpackage : srs_pkg

/* hw/srs_restart_seq.sv */
`timescale 1ns/1ps
`include "srs_cfg.svh"
module srs_restart_seq #(
  parameter int MS_CYCLES = `SRS_MS_NS / `SRS_CLK_NS,
  parameter logic [16:0] MAIN_DLY_MS = 17'd1,
  parameter int RATED_W = 3300
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mainsOkPin,
  input wire logic packFailPin,
  input wire logic packCutoffPin,
  input wire logic healthTestReqPin,
  input wire logic bootDone,
  input wire logic mainInReg,
  input wire logic protTrip,
  input wire srs_pkg::srs_shelf_t shelf,
  input wire logic bootloaderActive,
  input wire logic range277,
  input wire logic [15:0] outPowerW,
  input wire logic effWrEn,
  input wire logic effWrSel,
  input wire logic [4:0] effWrIdx,
  input wire logic [9:0] effWrData,
  input wire logic extMsgValid,
  input wire logic [1:0] extMsgKind,
  output logic extMsgAccept,
  output srs_pkg::srs_enables_t enables,
  output logic syncStrobeOut,
  output logic failLedRed,
  output logic greenLed,
  output logic softStartRst,
  output logic [15:0] inPowerW
);
  import srs_pkg::*;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pinRaw;
  logic [3:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  assign pinRaw = {healthTestReqPin, packCutoffPin, packFailPin, mainsOkPin};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_comb begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      flt_q <= 4'h0;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end
  logic mainsOk, packFail, packCutoff, testReq, busLost;
  assign mainsOk = flt_q[0];
  assign packFail = flt_q[1];
  assign packCutoff = flt_q[2];
  assign testReq = flt_q[3];
  assign busLost = ~shelf.peerAlive;
  // ---------------------------------------------------------------
  // millisecond tick and random source
  // ---------------------------------------------------------------
  logic [16:0] msCnt_q, msCnt_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic tick;
  assign tick = (msCnt_q == 17'(MS_CYCLES - 1));
  always_comb begin
    msCnt_d = tick ? 17'h0 : msCnt_q + 17'h1;
    lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msCnt_q <= 17'h0;
      lfsr_q <= 16'hace1;
    end else begin
      msCnt_q <= msCnt_d;
      lfsr_q <= lfsr_d;
    end
  end
  logic [10:0] nDraw;
  assign nDraw = 11'(lfsr_q % `SRS_RAND_SPAN);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  srs_state_t st_q, st_d;
  logic [16:0] cnt_q, cnt_d, outage_q, outage_d;
  logic [10:0] rand_q, rand_d;
  logic long_q, long_d, chg_q, chg_d, sync_d, sync_q, ss_d, ss_q;
  logic [12:0] target;
  logic deadBus, freeStart;
  assign target = long_q ? {rand_q, 2'b00} : {2'b00, rand_q};
  assign deadBus = packCutoff;
  assign freeStart = ~shelf.slot1Present | shelf.slot1InTest;
  always_comb begin
    st_d = st_q;
    cnt_d = tick ? cnt_q + 17'h1 : cnt_q;
    outage_d = outage_q;
    rand_d = rand_q;
    long_d = long_q;
    chg_d = chg_q;
    sync_d = 1'b0;
    ss_d = ss_q | protTrip;
    unique case (st_q)
      ST_BOOT: begin
        cnt_d = 17'h0;
        chg_d = 1'b0;
        if (bootDone && mainsOk && tick) begin
          st_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (!mainsOk) begin
          st_d = ST_BOOT;
        end else if (cnt_q >= MAIN_DLY_MS && mainInReg) begin
          st_d = ST_RUN;
          cnt_d = 17'h0;
        end
      end
      ST_RUN: begin
        if (cnt_q >= `SRS_CHG_MS) begin
          chg_d = 1'b1;
          cnt_d = cnt_q;
        end
        if (!mainsOk) begin
          st_d = ST_BACKUP;
          outage_d = 17'h0;
          chg_d = 1'b0;
        end else if (testReq) begin
          st_d = ST_TEST;
        end
      end
      ST_TEST: begin
        cnt_d = cnt_q;
        if (!testReq) begin
          st_d = ST_RUN;
        end
      end
      ST_BACKUP: begin
        if (tick) begin
          outage_d = outage_q + 17'h1;
        end
        if (outage_q > `SRS_SS_MS) begin
          ss_d = 1'b1;
        end
        if (outage_q >= `SRS_TIMEOUT_MS) begin
          st_d = ST_BOOT;
        end else if (mainsOk) begin
          st_d = ST_QUAL;
          cnt_d = 17'h0;
          rand_d = nDraw;
          long_d = (outage_q >= `SRS_LONG_MS);
        end
      end
      ST_QUAL: begin
        if (!mainsOk) begin
          st_d = ST_BACKUP;
        end else if (deadBus) begin
          st_d = ST_RUN;
          cnt_d = 17'h0;
        end else if (cnt_q >= `SRS_QUAL_MS && tick) begin
          cnt_d = 17'h0;
          if (shelf.isSlot1 && !testReq) begin
            st_d = ST_DELAY;
          end else if (!shelf.isSlot1 && freeStart) begin
            st_d = ST_RUN;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_DELAY: begin
        if (!mainsOk) begin
          st_d = ST_BACKUP;
        end else if (deadBus) begin
          st_d = ST_RUN;
          cnt_d = 17'h0;
        end else if (tick && cnt_q >= {4'h0, target}) begin
          st_d = ST_RUN;
          sync_d = 1'b1;
          cnt_d = 17'h0;
        end
      end
      ST_WAIT: begin
        if (!mainsOk) begin
          st_d = ST_BACKUP;
        end else if (shelf.syncIn || deadBus) begin
          st_d = ST_RUN;
          cnt_d = 17'h0;
        end
      end
    endcase
    if ((st_d == ST_RUN || st_d == ST_RAMP) && st_d != st_q
        && st_q != ST_TEST && !protTrip) begin
      ss_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_BOOT;
      cnt_q <= 17'h0;
      outage_q <= 17'h0;
      rand_q <= 11'h0;
      long_q <= 1'b0;
      chg_q <= 1'b0;
      sync_q <= 1'b0;
      ss_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      outage_q <= outage_d;
      rand_q <= rand_d;
      long_q <= long_d;
      chg_q <= chg_d;
      sync_q <= sync_d;
      ss_q <= ss_d;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic mainOn;
  assign mainOn = (st_q != ST_BOOT) && !(st_q == ST_RAMP && cnt_q < MAIN_DLY_MS);
  always_comb begin
    enables.relay = (st_q != ST_BOOT);
    enables.boost = (st_q == ST_RAMP || st_q == ST_RUN);
    enables.main = mainOn;
    enables.aux = mainOn && !busLost;
    enables.charger = chg_q && st_q == ST_RUN && !busLost;
    enables.stepUp = (st_q == ST_BACKUP || st_q == ST_TEST) && !packFail && !busLost;
  end
  assign syncStrobeOut = sync_q;
  assign failLedRed = busLost;
  assign softStartRst = ss_q;
  assign extMsgAccept = extMsgValid &&
      (extMsgKind == `SRS_MSG_REPORT || extMsgKind == `SRS_MSG_FW);
  // ---------------------------------------------------------------
  // green indicator
  // ---------------------------------------------------------------
  logic [16:0] blink_q, blink_d;
  logic green_q, green_d;
  always_comb begin
    blink_d = blink_q;
    green_d = green_q;
    if (!bootloaderActive) begin
      blink_d = 17'h0;
      green_d = (st_q != ST_BOOT) && !busLost;
    end else if (tick) begin
      blink_d = blink_q + 17'h1;
      if (blink_q >= `SRS_BLINK_MS - 17'h1) begin
        blink_d = 17'h0;
        green_d = ~green_q;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blink_q <= 17'h0;
      green_q <= 1'b0;
    end else begin
      blink_q <= blink_d;
      green_q <= green_d;
    end
  end
  assign greenLed = green_q;
  // ---------------------------------------------------------------
  // input power estimate
  // ---------------------------------------------------------------
  logic [9:0] eff_q [2][`SRS_EFF_PTS];
  logic [31:0] loadPct, idx32, inCalc;
  logic [4:0] idx;
  logic [9:0] effSel;
  logic [15:0] inPow_q, inPow_d;
  always_comb begin
    loadPct = 32'(outPowerW) * `SRS_PCT / 32'(RATED_W);
    idx32 = (loadPct <= `SRS_LOAD_MIN) ? 32'h0 : (loadPct - `SRS_LOAD_MIN) / `SRS_LOAD_STEP;
    idx = (idx32 > 32'(`SRS_EFF_PTS - 1)) ? 5'(`SRS_EFF_PTS - 1) : idx32[4:0];
    effSel = eff_q[range277][idx];
    inCalc = (effSel == 10'h0) ? 32'h0 : 32'(outPowerW) * `SRS_EFF_SCALE / 32'(effSel);
    inPow_d = (inCalc > 32'h0000ffff) ? 16'hffff : inCalc[15:0];
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inPow_q <= 16'h0;
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < `SRS_EFF_PTS; p++) begin
          eff_q[c][p] <= `SRS_EFF_RST;
        end
      end
    end else begin
      inPow_q <= inPow_d;
      if (effWrEn && effWrIdx < 5'(`SRS_EFF_PTS)) begin
        eff_q[effWrSel][effWrIdx] <= effWrData;
      end
    end
  end
  assign inPowerW = inPow_q;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  hold_off_a: assert property (st_q == ST_BOOT |-> !enables.boost && !enables.relay)
    else $error("converters on before boot");
  charger_wait_a: assert property (st_q == ST_RUN && cnt_q < `SRS_CHG_MS |-> !enables.charger)
    else $error("charger enabled early");
  main_order_a: assert property ($rose(enables.main) && st_q == ST_RAMP |-> enables.boost)
    else $error("main before boost");
  delay_end_a: assert property (st_q == ST_DELAY && mainsOk && !deadBus && tick
      && cnt_q >= {4'h0, target} |=> st_q == ST_RUN && syncStrobeOut)
    else $error("delayed start missed");
  strobe_boost_a: assert property (syncStrobeOut |-> enables.boost || busLost)
    else $error("strobe without boost");
  fresh_draw_a: assert property (st_q == ST_BACKUP && mainsOk
      && outage_q < `SRS_TIMEOUT_MS |=> rand_q == $past(nDraw))
    else $error("random not redrawn");
  dead_bus_a: assert property ((st_q == ST_QUAL || st_q == ST_DELAY || st_q == ST_WAIT)
      && mainsOk && deadBus |=> st_q == ST_RUN)
    else $error("dead bus not handled");
  bus_lost_a: assert property (busLost && st_q == ST_RUN |-> failLedRed && enables.main
      && enables.boost && !enables.aux && !enables.charger && !enables.stepUp)
    else $error("bus loss handling wrong");
  test_boost_a: assert property (st_q == ST_TEST |-> !enables.boost && enables.main)
    else $error("boost on during test");
  link_only_a: assert property (extMsgAccept |-> extMsgKind == `SRS_MSG_REPORT
      || extMsgKind == `SRS_MSG_FW)
    else $error("bad link message taken");
  cold_start_c: cover property (st_q == ST_RAMP ##1 st_q == ST_RUN);
  slot1_restart_c: cover property (st_q == ST_DELAY ##1 syncStrobeOut);
  wait_sync_c: cover property (st_q == ST_WAIT ##1 st_q == ST_RUN);
  health_test_c: cover property (st_q == ST_TEST);
endmodule : srs_restart_seq

/* bench/srs_peer_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// peers on the internal bus and the own battery pack
// ---------------------------------------------------------------
module srs_peer_model (
  input wire logic clk_sys,
  input wire logic isSlot1,
  input wire logic slot1Present,
  input wire logic slot1InTest,
  input wire logic peerAlive,
  input wire logic sendSync,
  input wire logic [15:0] packMv,
  input wire logic failReq,
  input wire logic testReq,
  output srs_pkg::srs_shelf_t shelf,
  output logic packFailPin,
  output logic packCutoffPin,
  output logic healthTestReqPin
);
  import srs_pkg::*;
  // cutoff threshold in mV
  localparam logic [15:0] CUTOFF_MV = 16'h8408;
  logic syncQ;
  // one broadcast pulse from slot 1
  always_ff @(posedge clk_sys) begin
    syncQ <= sendSync;
  end
  always_comb begin
    shelf.isSlot1 = isSlot1;
    shelf.slot1Present = slot1Present;
    shelf.slot1InTest = slot1InTest;
    shelf.peerAlive = peerAlive;
    shelf.syncIn = syncQ;
    packFailPin = failReq;
    healthTestReqPin = testReq;
    packCutoffPin = packMv < CUTOFF_MV;
  end
endmodule : srs_peer_model

/* bench/srs_restart_seq_tb.sv */
`timescale 1ns/1ps
module srs_restart_seq_tb;
  import srs_pkg::*;
  localparam int MSC = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mainsOk = 1'b0, bootDone = 1'b0, mainInReg = 1'b0, protTrip = 1'b0;
  logic isSlot1 = 1'b1, slot1Present = 1'b1, slot1InTest = 1'b0, peerAlive = 1'b1;
  logic sendSync = 1'b0, failReq = 1'b0, testReq = 1'b0, bootloaderActive = 1'b0;
  logic range277 = 1'b0, effWrEn = 1'b0, effWrSel = 1'b0, extMsgValid = 1'b0;
  logic [4:0] effWrIdx = 5'h0;
  logic [9:0] effWrData = 10'h0;
  logic [1:0] extMsgKind = 2'h0;
  logic [15:0] packMv = 16'hbb80;
  logic [15:0] outPowerW = 16'h0;
  srs_shelf_t shelf;
  srs_enables_t enables;
  logic packFailPin, packCutoffPin, healthTestReqPin, extMsgAccept, syncStrobeOut;
  logic failLedRed, greenLed, softStartRst;
  logic [15:0] inPowerW;
  int n_fail = 0;
  int compares = 0;
  int d1, d2, t;
  always #5 clk_sys = ~clk_sys;
  srs_restart_seq #(.MS_CYCLES(MSC)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .mainsOkPin(mainsOk), .packFailPin(packFailPin),
    .packCutoffPin(packCutoffPin), .healthTestReqPin(healthTestReqPin),
    .bootDone(bootDone), .mainInReg(mainInReg), .protTrip(protTrip), .shelf(shelf),
    .bootloaderActive(bootloaderActive), .range277(range277), .outPowerW(outPowerW),
    .effWrEn(effWrEn), .effWrSel(effWrSel), .effWrIdx(effWrIdx), .effWrData(effWrData),
    .extMsgValid(extMsgValid), .extMsgKind(extMsgKind), .extMsgAccept(extMsgAccept),
    .enables(enables), .syncStrobeOut(syncStrobeOut), .failLedRed(failLedRed),
    .greenLed(greenLed), .softStartRst(softStartRst), .inPowerW(inPowerW));
  srs_peer_model i_peer (
    .clk_sys(clk_sys), .isSlot1(isSlot1), .slot1Present(slot1Present),
    .slot1InTest(slot1InTest), .peerAlive(peerAlive), .sendSync(sendSync),
    .packMv(packMv), .failReq(failReq), .testReq(testReq), .shelf(shelf),
    .packFailPin(packFailPin), .packCutoffPin(packCutoffPin),
    .healthTestReqPin(healthTestReqPin));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic bad(input string msg);
    n_fail++;
    $display("wrong value at %0t ns: %s", $time, msg);
  endtask : bad
  task automatic timeUp(input string msg);
    bad(msg);
    print_verdict();
  endtask : timeUp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic chkBit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) bad(msg);
  endtask : chkBit
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) bad(msg);
  endtask : chkVal
  task automatic chkIn(input int got, input int lo, input int hi, input string msg);
    compares++;
    if (got < lo || got > hi) bad(msg);
  endtask : chkIn
  task automatic waitBoost(input int limMs, output int cycles);
    cycles = 0;
    #1;
    while (enables.boost !== 1'b1) begin
      if (cycles > limMs * MSC + 20) timeUp("boost never rose");
      cyc(1);
      cycles++;
    end
  endtask : waitBoost
  task automatic waitGreen(output int cycles);
    logic was;
    was = greenLed;
    cycles = 0;
    while (greenLed === was) begin
      if (cycles > 300 * MSC) timeUp("green never toggled");
      cyc(1);
      cycles++;
    end
  endtask : waitGreen
  task automatic outage(input int ms);
    @(posedge clk_sys) mainsOk <= 1'b0;
    cyc(ms * MSC);
    @(posedge clk_sys) mainsOk <= 1'b1;
    #1;
  endtask : outage
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(12);
    @(posedge clk_sys) rst <= 1'b0;
    @(posedge clk_sys) mainsOk <= 1'b1;
    cyc(40);
    chkBit(|enables, 1'b0, "enables before boot");
    @(posedge clk_sys) bootDone <= 1'b1;
    waitBoost(20, t);
    chkBit(enables.relay, 1'b1, "relay with boost");
    chkBit(enables.main, 1'b0, "main before boost");
    cyc(3 * MSC);
    chkBit(enables.main & enables.aux, 1'b1, "main and aux");
    @(posedge clk_sys) mainInReg <= 1'b1;
    cyc(1990 * MSC);
    chkBit(enables.charger, 1'b0, "charger early");
    cyc(20 * MSC);
    chkBit(enables.charger, 1'b1, "charger late");
    done("cold start");
    outage(100);
    chkBit(softStartRst, 1'b1, "soft start after loss");
    waitBoost(3100, d1);
    chkIn(d1, 1000 * MSC, 3002 * MSC + 20, "short delay");
    chkBit(syncStrobeOut, 1'b1, "strobe with boost");
    cyc(1);
    chkBit(syncStrobeOut, 1'b0, "strobe length");
    chkBit(softStartRst, 1'b0, "soft start released");
    outage(100);
    waitBoost(3100, d2);
    chkBit(d1 != d2, 1'b1, "same draw twice");
    outage(8100);
    waitBoost(9100, t);
    chkIn(t, 1000 * MSC, 9002 * MSC + 20, "long delay");
    done("slot1 restart");
    @(posedge clk_sys);
    isSlot1 <= 1'b0;
    slot1Present <= 1'b0;
    outage(50);
    waitBoost(1100, t);
    chkIn(t, 1000 * MSC, 1002 * MSC + 20, "no slot1 start");
    chkBit(syncStrobeOut, 1'b0, "receiver strobe");
    @(posedge clk_sys);
    slot1Present <= 1'b1;
    slot1InTest <= 1'b1;
    outage(50);
    waitBoost(1100, t);
    chkIn(t, 1000 * MSC, 1002 * MSC + 20, "slot1 test start");
    @(posedge clk_sys);
    slot1InTest <= 1'b0;
    failReq <= 1'b1;
    outage(50);
    cyc(1200 * MSC);
    chkBit(enables.boost, 1'b0, "failed pack early");
    @(posedge clk_sys) sendSync <= 1'b1;
    @(posedge clk_sys) sendSync <= 1'b0;
    waitBoost(2, t);
    chkIn(t, 0, 3, "start on strobe");
    @(posedge clk_sys) failReq <= 1'b0;
    outage(50);
    cyc(500 * MSC);
    @(posedge clk_sys) packMv <= 16'h7530;
    waitBoost(5, t);
    chkIn(t, 0, 12, "dead bus start");
    done("receivers");
    @(posedge clk_sys);
    packMv <= 16'hbb80;
    testReq <= 1'b1;
    cyc(10);
    chkBit(enables.boost, 1'b0, "boost in test");
    chkBit(enables.main, 1'b1, "main in test");
    @(posedge clk_sys) testReq <= 1'b0;
    waitBoost(5, t);
    @(posedge clk_sys) peerAlive <= 1'b0;
    cyc(5);
    chkBit(failLedRed, 1'b1, "red on bus loss");
    chkBit(enables.main, 1'b1, "main on bus loss");
    chkBit(enables.boost, 1'b1, "boost on bus loss");
    chkBit(enables.stepUp | enables.charger | enables.aux, 1'b0, "others");
    @(posedge clk_sys) peerAlive <= 1'b1;
    @(posedge clk_sys) bootloaderActive <= 1'b1;
    waitGreen(t);
    waitGreen(t);
    waitGreen(t);
    chkIn(t, 250 * MSC - 1, 250 * MSC + 1, "blink period");
    @(posedge clk_sys) bootloaderActive <= 1'b0;
    done("bus, test and blink");
    @(posedge clk_sys) outPowerW <= 16'h0640;
    cyc(3);
    chkVal(inPowerW, 16'h0682, "low range power");
    for (int i = 0; i < 19; i++) begin
      @(posedge clk_sys);
      effWrEn <= 1'b1;
      effWrSel <= 1'b1;
      effWrIdx <= i[4:0];
      effWrData <= 10'h320;
    end
    @(posedge clk_sys);
    effWrEn <= 1'b0;
    range277 <= 1'b1;
    cyc(3);
    chkVal(inPowerW, 16'h07d0, "high range power");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      extMsgValid <= 1'b1;
      extMsgKind <= k[1:0];
      cyc(1);
      chkBit(extMsgAccept, k == 1 || k == 2, "link filter");
    end
    @(posedge clk_sys) protTrip <= 1'b1;
    cyc(3);
    chkBit(softStartRst, 1'b1, "soft start on trip");
    done("power, link and trip");
    print_verdict();
  end
endmodule : srs_restart_seq_tb
